// ==== logic/csl_regs.svh ====
`ifndef CSL_REGS_SVH
`define CSL_REGS_SVH

// ----------------------------------------------------------------
// configuration region layout
// ----------------------------------------------------------------
`define CSL_NUM_WORDS 9
`define CSL_LAST_IDX 4'h8
`define CSL_FIRST_IDX 4'h0
`define CSL_IDX_STEP 4'h1
`define CSL_CFG_BASE 24'h015700
`define CSL_OFS_0 8'h80
`define CSL_OFS_1 8'h90
`define CSL_OFS_2 8'h94
`define CSL_OFS_3 8'h98
`define CSL_OFS_4 8'h9c
`define CSL_OFS_5 8'ha0
`define CSL_OFS_6 8'ha4
`define CSL_OFS_7 8'ha8
`define CSL_OFS_8 8'hac

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CSL_CFG_LSB 0
`define CSL_CFG_MSB 15
`define CSL_SEC_IDX 0
`define CSL_GSS_LSB 6
`define CSL_GSS_MSB 7
`define CSL_GSS_OPEN 2'h3
`define CSL_SHADOW_RST 16'h0000
`define CSL_ADDR_RST 24'h000000
`define CSL_DATA_RST 32'h00000000

`endif

// ==== logic/csl_pkg.sv ====
`default_nettype none
`include "csl_regs.svh"
package csl_pkg;
   // ----------------------------------------------------------------
   // loader states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CSL_ISSUE = 2'h0, // request next word
      CSL_WAIT = 2'h1,  // waiting for flash answer
      CSL_DONE = 2'h2   // all shadows loaded
   } csl_state_type;

   // all shadow words, index 0 is the security word
   typedef logic [`CSL_NUM_WORDS-1:0][15:0] csl_shadow_type;

   // reset sources other than power-on (power-on is rst)
   typedef struct packed {
      logic brownOut;
      logic watchdog;
      logic software;
      logic trap;
      logic other;
   } csl_reset_src_type;

   // loader state
   typedef struct packed {
      csl_state_type state;
      logic [3:0] idx;
      csl_shadow_type shadow;
      logic hold;
      logic done;
      logic eraseFlag;
      logic protect;
   } csl_main_type;

   // fetch engine state
   typedef struct packed {
      logic req;
      logic [23:0] addr;
      logic valid;
      logic [31:0] data;
   } csl_fetch_type;
endpackage : csl_pkg
`default_nettype wire

// ==== logic/csl_word_fetch.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "csl_regs.svh"
module csl_word_fetch
   import csl_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // loader side
   input wire logic start,
   input wire logic abort,
   input wire logic [3:0] index,
   output logic wordValid,
   output logic [31:0] wordData,
   // flash side
   input wire logic flashAck,
   input wire logic [31:0] flashData,
   output logic flashReq,
   output logic [23:0] flashAddr
);
   // ----------------------------------------------------------------
   // word offsets inside the reserved top region
   // ----------------------------------------------------------------
   localparam logic [`CSL_NUM_WORDS-1:0][7:0] OFS_TABLE = {
      `CSL_OFS_8, `CSL_OFS_7, `CSL_OFS_6, `CSL_OFS_5, `CSL_OFS_4,
      `CSL_OFS_3, `CSL_OFS_2, `CSL_OFS_1, `CSL_OFS_0};

   csl_fetch_type cur; // registered state
   csl_fetch_type next_cur; // next state

   // request held until acknowledged, abort wins
   always_comb begin
      next_cur = cur;
      next_cur.valid = 1'b0;
      if (abort) begin
         // reset source mid-transfer, drop the request
         next_cur.req = 1'b0;
      end else if (cur.req && flashAck) begin
         next_cur.req = 1'b0;
         next_cur.valid = 1'b1;
         next_cur.data = flashData;
      end else if (start && !cur.req) begin
         next_cur.req = 1'b1;
         // fixed region at the top of program flash
         next_cur.addr = `CSL_CFG_BASE + {16'h0000, OFS_TABLE[index]};
      end
   end

   // state register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cur <= '{req: 1'b0, addr: `CSL_ADDR_RST, valid: 1'b0, data: `CSL_DATA_RST};
      end else begin
         cur <= next_cur;
      end
   end

   assign flashReq = cur.req;
   assign flashAddr = cur.addr;
   assign wordValid = cur.valid;
   assign wordData = cur.data;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_ADDR_IN_REGION: assert property (@(posedge clock) disable iff (rst)
      flashReq |-> (flashAddr >= `CSL_CFG_BASE + {16'h0000, `CSL_OFS_0}
         && flashAddr <= `CSL_CFG_BASE + {16'h0000, `CSL_OFS_8}))
      else $error("flash address outside configuration region");
   AST_REQ_HELD: assert property (@(posedge clock) disable iff (rst)
      flashReq && !flashAck && !abort |=> flashReq && $stable(flashAddr))
      else $error("flash request dropped before acknowledge");
endmodule : csl_word_fetch
`default_nettype wire

// ==== logic/csl_loader.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "csl_regs.svh"
module csl_loader
   import csl_pkg::*;
(
   // clock and power-on reset
   input wire logic clock,
   input wire logic rst,
   // other reset sources, levels
   input wire csl_reset_src_type resetSrc,
   // flash read port
   input wire logic flashAck,
   input wire logic [31:0] flashData,
   output logic flashReq,
   output logic [23:0] flashAddr,
   // flash controller event, one-cycle pulse
   input wire logic eraseLastPage,
   // configuration outputs
   output csl_shadow_type configWords,
   output logic cpuHold,
   output logic loadDone,
   output logic codeProtect
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   csl_main_type cur; // registered state
   csl_main_type next_cur; // next state
   logic anySrc; // some non power-on reset is active
   logic fetchStart; // ask fetch engine for a word
   logic wordValid; // fetched word present, one cycle
   logic [31:0] wordData; // fetched word
   logic [1:0] gssField; // security field of next shadow

   // levels, not edges: a long brown-out keeps the copy parked at word zero
   assign anySrc = |resetSrc;

   // ----------------------------------------------------------------
   // fetch engine
   // ----------------------------------------------------------------
   // kept apart so a reset source can drop a half-done flash read cleanly;
   // the flash side must tolerate such a dropped request
   csl_word_fetch u_fetch (
      .clock(clock),
      .rst(rst),
      .start(fetchStart),
      .abort(anySrc),
      .index(cur.idx),
      .wordValid(wordValid),
      .wordData(wordData),
      .flashAck(flashAck),
      .flashData(flashData),
      .flashReq(flashReq),
      .flashAddr(flashAddr)
   );

   // start only when no reset source holds the loader
   assign fetchStart = (cur.state == CSL_ISSUE) && !anySrc;

   // ----------------------------------------------------------------
   // load sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_cur = cur;
      gssField = 2'h0;
      if (anySrc) begin
         // any reset source restarts the copy from word zero
         next_cur.state = CSL_ISSUE;
         next_cur.idx = `CSL_FIRST_IDX;
         next_cur.done = 1'b0;
      end else begin
         // one issue/wait pair per word, index walking first to last
         case (cur.state)
            CSL_ISSUE: begin
               // request issued this cycle
               next_cur.state = CSL_WAIT;
            end
            CSL_WAIT: begin
               if (wordValid) begin
                  // only low half carries configuration
                  next_cur.shadow[cur.idx] = wordData[`CSL_CFG_MSB:`CSL_CFG_LSB];
                  if (cur.idx == `CSL_LAST_IDX) begin
                     next_cur.state = CSL_DONE;
                     next_cur.done = 1'b1;
                  end else begin
                     next_cur.idx = cur.idx + `CSL_IDX_STEP;
                     next_cur.state = CSL_ISSUE;
                  end
               end else begin
                  // word still in flight, keep waiting
                  next_cur.state = CSL_WAIT;
               end
            end
            CSL_DONE: begin
               // stays loaded until the next reset of any kind
               next_cur.state = CSL_DONE;
            end
            default: begin
               // illegal code: restart the copy from word zero
               next_cur.state = CSL_ISSUE;
               next_cur.idx = `CSL_FIRST_IDX;
            end
         endcase
      end
      // processor released only with a full shadow set
      next_cur.hold = !next_cur.done;
      // erase flag: set beats the clear at load completion
      next_cur.eraseFlag = (cur.eraseFlag && !(next_cur.done && !cur.done)) || eraseLastPage;
      // next-state values, so protection lands on the same edge as the word
      // cleared words read as zero, which means protected
      gssField = next_cur.shadow[`CSL_SEC_IDX][`CSL_GSS_MSB:`CSL_GSS_LSB];
      next_cur.protect = next_cur.eraseFlag || (gssField != `CSL_GSS_OPEN);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // power loss drops shadows; protected until reloaded
   // hold starts high so the processor never runs on empty shadows
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cur.state <= CSL_ISSUE;
         cur.idx <= `CSL_FIRST_IDX;
         cur.shadow <= {`CSL_NUM_WORDS{`CSL_SHADOW_RST}};
         cur.hold <= 1'b1;
         cur.done <= 1'b0;
         cur.eraseFlag <= 1'b0;
         cur.protect <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   assign configWords = cur.shadow;
   assign cpuHold = cur.hold;
   assign loadDone = cur.done;
   assign codeProtect = cur.protect;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // helper state for the checks only, never read by the loader
   logic seenLoad; // helper: a word has been stored since power-on
   logic [3:0] lastIdx; // helper: index of the word last stored
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         seenLoad <= 1'b0;
         lastIdx <= `CSL_FIRST_IDX;
      end else begin
         seenLoad <= seenLoad || (wordValid && cur.state == CSL_WAIT && !anySrc);
         if (wordValid && cur.state == CSL_WAIT && !anySrc) begin
            lastIdx <= cur.idx;
         end
      end
   end

   AST_HOLD_UNTIL_LOADED: assert property (cpuHold == !loadDone)
      else $error("processor hold does not match load state");
   AST_SOURCE_RESTARTS: assert property (anySrc |=> cpuHold && !loadDone
      && cur.idx == `CSL_FIRST_IDX && !flashReq)
      else $error("reset source did not restart the load");
   AST_LOW_HALF_STORED: assert property (wordValid && cur.state == CSL_WAIT && !anySrc
      |=> configWords[$past(cur.idx)] == $past(wordData[15:0]))
      else $error("shadow word not taken from low half");
   AST_DONE_AFTER_LAST: assert property ($rose(loadDone) |-> lastIdx == `CSL_LAST_IDX)
      else $error("load finished before the last word");
   AST_LOADED_STAYS: assert property (loadDone && !anySrc |=> loadDone && $stable(configWords))
      else $error("shadows changed without a reset");
   AST_VOLATILE_START: assert property (!seenLoad |-> configWords == {`CSL_NUM_WORDS{`CSL_SHADOW_RST}})
      else $error("shadow not cleared after power-on");
   AST_ERASE_PROTECTS: assert property (eraseLastPage |=> codeProtect ##1 (codeProtect || $rose(loadDone)))
      else $error("last page erase did not enable protection");
   AST_WORD_WITHIN: assert property (fetchStart |-> ##[1:300] (wordValid || anySrc || flashReq))
      else $error("fetch start produced no flash request");

   // the word index never leaves the nine-word region
   AST_IDX_IN_RANGE: assert property (cur.idx <= `CSL_LAST_IDX)
      else $error("word index beyond configuration region");
   // flash is only read while the processor is still held
   AST_REQ_WHILE_HELD: assert property (flashReq |-> cpuHold)
      else $error("flash read after processor release");
   // shadows change only on an accepted word
   AST_SHADOW_ONLY_ON_WORD: assert property (!(wordValid && cur.state == CSL_WAIT && !anySrc)
      |=> $stable(configWords))
      else $error("shadow changed without a flash word");
   // erase keeps protection up until a later load clears the flag
   AST_ERASE_STICKS: assert property (cur.eraseFlag |-> codeProtect)
      else $error("protection off while erase flag set");
   // without an erase, protection follows the security field
   AST_PROTECT_FOLLOWS_WORD: assert property (!cur.eraseFlag
      |-> codeProtect == (configWords[`CSL_SEC_IDX][`CSL_GSS_MSB:`CSL_GSS_LSB] != `CSL_GSS_OPEN))
      else $error("protection does not follow security field");
   // release only after a cycle with no reset source active
   AST_RELEASE_SOURCES_IDLE: assert property ($fell(cpuHold) |-> !$past(anySrc))
      else $error("processor released while a reset source was active");
   // a reset source never lets a fetched word through
   AST_SOURCE_DROPS_WORD: assert property (anySrc |=> !wordValid)
      else $error("word delivered during a reset source");
   // each stored word before the last moves the index on by one
   AST_STORE_ADVANCES: assert property (wordValid && cur.state == CSL_WAIT && !anySrc
      && cur.idx != `CSL_LAST_IDX |=> cur.idx == $past(cur.idx) + `CSL_IDX_STEP)
      else $error("index did not advance after a stored word");
   // the first and last reads land on the region's end words
   AST_FIRST_ADDR: assert property (fetchStart && cur.idx == `CSL_FIRST_IDX
      |=> flashAddr == `CSL_CFG_BASE + {16'h0000, `CSL_OFS_0})
      else $error("first read not at the security word");
   AST_LAST_ADDR: assert property (fetchStart && cur.idx == `CSL_LAST_IDX
      |=> flashAddr == `CSL_CFG_BASE + {16'h0000, `CSL_OFS_8})
      else $error("last read not at the final word");

   // main scenarios the bench is expected to reach
   COV_FULL_LOAD: cover property ($rose(loadDone));
   COV_RELOAD: cover property (loadDone ##1 anySrc ##[1:400] $rose(loadDone));
   COV_ERASE: cover property (loadDone && eraseLastPage);
   COV_OPEN: cover property (loadDone && !codeProtect);
   COV_ABORT_READ: cover property (flashReq && anySrc);
endmodule : csl_loader
`default_nettype wire

// ==== verification/csl_flash_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// flash array answering word reads
// ----------------------------------------
module csl_flash_model
   import csl_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // stored content and answer delay
   input wire logic [15:0] secWord,
   input wire logic [7:0] salt,
   input wire logic [15:0] upperBits,
   input wire logic [3:0] lag,
   // read port
   input wire logic flashReq,
   input wire logic [23:0] flashAddr,
   output logic flashAck,
   output logic [31:0] flashData
);
   logic [3:0] waitCount; // cycles spent on this request
   logic answered; // one answer per request
   // answer after lag cycles; a dropped request only restarts the wait
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flashAck <= 1'b0;
         flashData <= 32'h00000000;
         waitCount <= 4'h0;
         answered <= 1'b0;
      end else begin
         flashAck <= 1'b0;
         flashData <= ~flashData; // idle bus never repeats the last word
         if (!flashReq) begin
            waitCount <= 4'h0;
            answered <= 1'b0;
         end else if (!answered && waitCount == lag) begin
            flashAck <= 1'b1;
            answered <= 1'b1;
            // upper half is all ones unless a test says otherwise
            flashData <= {upperBits, ((flashAddr[7:0] == 8'h80) ? secWord : {salt, flashAddr[7:0]})};
         end else begin
            waitCount <= waitCount + 4'h1;
         end
      end
   end
endmodule : csl_flash_model
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "csl_regs.svh"
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %0t %s", $time, m); end end
module testbench
   import csl_pkg::*;
;
   logic clock, rst, eraseLastPage, flashAck, flashReq, cpuHold, loadDone, codeProtect;
   csl_reset_src_type resetSrc; // other reset sources
   logic [31:0] flashData;
   logic [23:0] flashAddr;
   csl_shadow_type configWords;
   logic [15:0] secWord, upperBits; // flash content controls
   logic [7:0] salt;
   logic [3:0] lag; // flash answer delay
   int miscompares = 0, tests_run = 0, cycles = 0;
   logic [23:0] addrs[$]; // accepted read addresses
   csl_loader u_dut (.clock(clock), .rst(rst), .resetSrc(resetSrc), .flashAck(flashAck),
      .flashData(flashData), .flashReq(flashReq), .flashAddr(flashAddr), .eraseLastPage(eraseLastPage),
      .configWords(configWords), .cpuHold(cpuHold), .loadDone(loadDone), .codeProtect(codeProtect));
   csl_flash_model u_flash (.clock(clock), .rst(rst), .secWord(secWord), .salt(salt),
      .upperBits(upperBits), .lag(lag), .flashReq(flashReq), .flashAddr(flashAddr),
      .flashAck(flashAck), .flashData(flashData));
   // ----------------------------------------
   // clock, timeout and monitors
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // log accepted reads; ceiling is far above ~650 expected cycles
   always @(posedge clock) begin
      cycles++;
      if (flashReq && flashAck && resetSrc === 5'h00) addrs.push_back(flashAddr);
      if (cycles == 5000) begin
         miscompares++;
         wrap_up();
      end
   end
   // processor must stay held until the load is complete
   always @(negedge clock) `CHK(cpuHold, ~loadDone, "hold vs done")
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] ofsOf(int i);
      return (i == 0) ? 8'h80 : 8'h8c + 8'(4 * i);
   endfunction : ofsOf
   function automatic logic [15:0] expWord(int i);
      return (i == 0) ? secWord : {salt, ofsOf(i)};
   endfunction : expWord
   task automatic wait_done();
      int n = 0;
      while (loadDone !== 1'b1 && n < 300) begin
         @(negedge clock);
         n++;
      end
      `CHK(loadDone, 1'b1, "load did not finish")
   endtask : wait_done
   task automatic check_load();
      for (int i = 0; i < `CSL_NUM_WORDS; i++) begin
         `CHK(configWords[i], expWord(i), "shadow word")
         `CHK(addrs[i], `CSL_CFG_BASE + 24'(ofsOf(i)), "word address")
      end
      `CHK(addrs.size(), `CSL_NUM_WORDS, "word count")
      `CHK(codeProtect, secWord[7:6] != 2'b11, "protection")
   endtask : check_load
   task automatic reload(int b);
      @(negedge clock);
      resetSrc = csl_reset_src_type'(5'h01 << b);
      repeat (2) @(negedge clock);
      `CHK({cpuHold, loadDone}, 2'b10, "source reset state")
      addrs.delete();
      resetSrc = 5'h00;
      wait_done();
   endtask : reload
   task automatic power_on();
      rst = 1'b1;
      repeat (3) @(negedge clock);
      `CHK(configWords, '0, "shadow kept in reset")
      `CHK(codeProtect, 1'b1, "protect in reset")
      addrs.delete();
      rst = 1'b0;
      wait_done();
      check_load();
   endtask : power_on
   task automatic partial(int k);
      int n = 0;
      resetSrc = 5'h08;
      @(negedge clock);
      resetSrc = 5'h00;
      addrs.delete();
      while (addrs.size() < k && n < 100) begin
         @(negedge clock);
         n++;
      end
      `CHK(loadDone, 1'b0, "done mid load")
   endtask : partial
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_sources();
      for (int b = 0; b < 5; b++) begin
         salt = 8'h20 + 8'(b);
         upperBits = b[0] ? 16'h0000 : 16'hffff; // odd passes break the all-ones fill
         secWord = {8'h3c, b[1:0], 6'h2a};
         lag = 4'(b);
         reload(b);
         check_load();
      end
      $display("test reset sources done");
   endtask : t_sources
   task automatic t_erase();
      secWord = 16'h00c0;
      reload(2);
      check_load();
      eraseLastPage = 1'b1;
      @(negedge clock);
      eraseLastPage = 1'b0;
      `CHK(codeProtect, 1'b1, "erase protect")
      repeat (5) @(negedge clock);
      `CHK(codeProtect, 1'b1, "erase protect held")
      secWord = 16'h0000; // erased security word
      reload(1);
      check_load();
      $display("test erase done");
   endtask : t_erase
   task automatic t_abort();
      secWord = 16'h00c0;
      lag = 4'h2;
      partial(3);
      reload(3);
      check_load();
      salt = 8'h77;
      partial(5);
      power_on();
      $display("test abort done");
   endtask : t_abort
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up
   initial begin
      rst = 1'b1;
      resetSrc = 5'h00;
      eraseLastPage = 1'b0;
      secWord = 16'h00c0;
      salt = 8'h11;
      upperBits = 16'hffff;
      lag = 4'h0;
      power_on();
      $display("test power up done");
      t_sources();
      t_erase();
      t_abort();
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
